// [rtl/smb_pkg.sv]
/*
  Shared constants and types of the serial configuration slave: the slave
  address, command code fields, power-up register image and the link state
  encoding.
  Assumes a two-wire host that clocks the link and keeps data stable while
  the serial clock is high.
*/
package smb_pkg;

  // ----------------------------------------------------------------------
  // Addressing and command code fields
  // ----------------------------------------------------------------------
  localparam logic [6:0] SMB_SLV_ADDR = 7'h69;  // Address byte d2 without its direction bit
  localparam int SMB_CMD_MODE_BIT = 7;          // 1 = single byte, 0 = block
  localparam int SMB_OFS_W = 7;                 // Offset field width, bits 6..0
  localparam logic [6:0] SMB_BLK_OFS = 7'h00;   // Blocks always start at byte 0
  localparam int SMB_BYTE_W = 8;
  localparam int SMB_BIT_LAST = 7;              // Bit counter value of a byte's last bit

  // ----------------------------------------------------------------------
  // Register defaults and sizing
  // ----------------------------------------------------------------------
  localparam int SMB_NUM_BYTES = 8;
  localparam int SMB_RST_TBL_BYTES = 8;
  // Byte 0 in the low lane; bytes beyond the table reset to zero
  localparam logic [63:0] SMB_RST_TBL = 64'h0000_0007_00ff_f7ff;
  localparam int SMB_FIFO_DEPTH = 2;

  // ----------------------------------------------------------------------
  // Link-side sequencer states, one-hot
  // ----------------------------------------------------------------------
  typedef enum logic [10:0] {
    SMB_IDLE = 11'h001,
    SMB_ADDR = 11'h002,
    SMB_ACK_A = 11'h004,
    SMB_CMD = 11'h008,
    SMB_ACK_C = 11'h010,
    SMB_CNT = 11'h020,
    SMB_ACK_N = 11'h040,
    SMB_WDAT = 11'h080,
    SMB_ACK_W = 11'h100,
    SMB_TX = 11'h200,
    SMB_RACK = 11'h400
  } smb_state_e;

endpackage

// [rtl/smb_fifo2.sv]
/*
  Small first-in first-out buffer with valid/ready on both sides.
  Assumes one clock, an active-low asynchronous reset and an enable that
  freezes all state while low.
*/
`timescale 1ns/1ps
`default_nettype none

module smb_fifo2 #(
  parameter int W = 15,
  parameter int DEPTH = 2
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic en_i,
  input wire logic in_valid_i,
  input wire logic [W-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [W-1:0] out_data_o,
  input wire logic out_ready_i
);
  import smb_pkg::*;

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2) begin
    $error("smb_fifo2 needs a depth of at least two");
  end

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } smb_fifo_s;

  smb_fifo_s q_r;
  smb_fifo_s q_nxt;
  logic push;
  logic pop;

  function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction

  // Honest flags straight from the fill count
  assign in_ready_o = (q_r.cnt != (AW + 1)'(DEPTH));
  assign out_valid_o = (q_r.cnt != '0);
  assign out_data_o = q_r.mem[q_r.rp];
  assign push = en_i & in_valid_i & in_ready_o;
  assign pop = en_i & out_valid_o & out_ready_i;

  // Next state: write at the tail, read at the head
  always_comb begin
    q_nxt = q_r;
    if (push) begin
      q_nxt.mem[q_r.wp] = in_data_i;
      q_nxt.wp = wrap_inc(q_r.wp);
    end
    if (pop) begin
      q_nxt.rp = wrap_inc(q_r.rp);
    end
    q_nxt.cnt = (AW + 1)'(q_r.cnt + {AW'(0), push} - {AW'(0), pop});
  end

  // State register
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q_r <= '0;
    end else if (en_i) begin
      q_r <= q_nxt;
    end
  end

endmodule

`default_nettype wire

// [rtl/smb_slave.sv]
/*
  Two-wire serial slave giving a host byte and block access to the
  configuration bytes of the clock synthesizer.
  Assumes the host drives the serial clock, holds data stable while it is
  high and waits at least eight clock periods between the bytes of one
  transfer; the register file lives on the system clock.
*/
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Command bit 7 picks block or byte transfer
// - Bits 6..0 give byte offset; block uses zero
// - Start, address+write, command, each byte acknowledged
// - Block write: count, then acknowledged data bytes
// - Bypass bit set skips block write count
// - Block read: restart, read address, count, data
// - Byte write: one acknowledged data byte, stop
// - Byte read: restart, one byte, host refuses
// - Answer only address d2, ignore others
// - Block bytes ascend, MSB first, stoppable anywhere
// - Registers take defaults at reset
module smb_slave #(
  parameter int NUM_BYTES = smb_pkg::SMB_NUM_BYTES,
  parameter int FIFO_DEPTH = smb_pkg::SMB_FIFO_DEPTH
) (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic byte_cnt_bypass_i,
  input wire logic upd_ready_i,
  output logic [NUM_BYTES*smb_pkg::SMB_BYTE_W-1:0] cfg_o
);
  import smb_pkg::*;

  localparam int RW = NUM_BYTES * SMB_BYTE_W;
  localparam int FW = SMB_OFS_W + SMB_BYTE_W;

  if (NUM_BYTES < 1 || NUM_BYTES > 128) begin
    $error("smb_slave: NUM_BYTES must lie in 1..128");
  end

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [RW-1:0] rst_image();
    logic [RW-1:0] r;
    r = '0;
    for (int i = 0; i < NUM_BYTES; i++) begin
      if (i < SMB_RST_TBL_BYTES) begin
        r[i*8 +: 8] = SMB_RST_TBL[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic in_range(input logic [6:0] ofs);
    return (int'(ofs) < NUM_BYTES);
  endfunction

  function automatic logic [7:0] byte_rd(input logic [RW-1:0] r, input logic [6:0] ofs);
    return in_range(ofs) ? r[int'(ofs)*8 +: 8] : 8'h00;
  endfunction

  localparam logic [RW-1:0] REGS_RST = rst_image();
  localparam logic [7:0] BLK_COUNT = 8'(NUM_BYTES);

  // ----------------------------------------------------------------------
  // State records
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [1:0] wsync;
    logic wseen;
    logic [1:0] rsync;
    logic rseen;
    logic [7:0] rd_data;
    logic [RW-1:0] regs;
  } smb_sys_s;

  typedef struct packed {
    smb_state_e st;
    logic [2:0] bcnt;
    logic [7:0] sr;
    logic [7:0] txsr;
    logic rw;
    logic blk;
    logic cmd_ok;
    logic wrote;
    logic st_seen;
    logic [6:0] ptr;
    logic wr_tgl;
    logic [6:0] wr_ofs;
    logic [7:0] wr_dat;
    logic rd_tgl;
    logic [6:0] rd_ofs;
    logic [1:0] byp;
  } smb_link_s;

  localparam smb_sys_s SYS_RST = '{wsync: 2'h0, wseen: 1'b0, rsync: 2'h0, rseen: 1'b0,
                                   rd_data: 8'h00, regs: REGS_RST};
  localparam smb_link_s LINK_RST = '{st: SMB_IDLE, bcnt: 3'h0, sr: 8'h00, txsr: 8'h00,
                                     rw: 1'b0, blk: 1'b0, cmd_ok: 1'b0, wrote: 1'b0,
                                     st_seen: 1'b0, ptr: 7'h00, wr_tgl: 1'b0,
                                     wr_ofs: 7'h00, wr_dat: 8'h00, rd_tgl: 1'b0,
                                     rd_ofs: 7'h00, byp: 2'h0};

  smb_sys_s s_r;
  smb_sys_s s_nxt;
  smb_link_s l_r;
  smb_link_s l_nxt;
  logic start_tgl_r;
  logic sda_oe_r;
  logic sda_oe_nxt;
  logic [7:0] sr_full;
  logic wr_pend;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [FW-1:0] fifo_out_data;
  logic commit;

  // ----------------------------------------------------------------------
  // Start detector
  // ----------------------------------------------------------------------
  // Data falling while the clock is high marks a (repeated) start; the
  // toggle settles half a clock before the next rising edge samples it
  always_ff @(negedge sda_i or negedge rstn_i) begin
    if (!rstn_i) begin
      start_tgl_r <= 1'b0;
    end else if (scl_i) begin
      start_tgl_r <= ~start_tgl_r;
    end
  end

  // ----------------------------------------------------------------------
  // Link sequencer, on the rising serial clock
  // ----------------------------------------------------------------------
  assign sr_full = {l_r.sr[6:0], sda_i};

  // Bits are taken MSB first; the sequencer never waits for a stop, so a
  // transfer may end after any whole byte
  always_comb begin
    l_nxt = l_r;
    l_nxt.byp = {l_r.byp[0], byte_cnt_bypass_i};
    if (start_tgl_r != l_r.st_seen) begin
      // First address bit of a new or repeated start
      l_nxt.st_seen = start_tgl_r;
      l_nxt.st = SMB_ADDR;
      l_nxt.sr = {7'h00, sda_i};
      l_nxt.bcnt = 3'h1;
    end else begin
      case (l_r.st)
        SMB_ADDR, SMB_CMD, SMB_CNT, SMB_WDAT: begin
          l_nxt.sr = sr_full;
          l_nxt.bcnt = 3'(l_r.bcnt + 3'h1);
          if (l_r.bcnt == 3'(SMB_BIT_LAST)) begin
            case (l_r.st)
              SMB_ADDR: begin
                // Reads only after a command has set the offset
                if (sr_full[7:1] == SMB_SLV_ADDR && (!sr_full[0] || l_r.cmd_ok)) begin
                  l_nxt.st = SMB_ACK_A;
                  l_nxt.rw = sr_full[0];
                end else begin
                  l_nxt.st = SMB_IDLE;
                end
              end
              SMB_CMD: begin
                l_nxt.blk = ~sr_full[SMB_CMD_MODE_BIT];
                l_nxt.ptr = sr_full[SMB_CMD_MODE_BIT] ? sr_full[6:0] : SMB_BLK_OFS;
                l_nxt.rd_ofs = sr_full[SMB_CMD_MODE_BIT] ? sr_full[6:0] : SMB_BLK_OFS;
                l_nxt.rd_tgl = ~l_r.rd_tgl; // Prefetch the first read byte early
                l_nxt.cmd_ok = 1'b1;
                l_nxt.st = SMB_ACK_C;
              end
              SMB_CNT: begin
                l_nxt.st = SMB_ACK_N;
              end
              default: begin
                // Byte mode takes one data byte only; extras go unanswered
                if (!l_r.blk && l_r.wrote) begin
                  l_nxt.st = SMB_IDLE;
                end else begin
                  l_nxt.wr_tgl = ~l_r.wr_tgl;
                  l_nxt.wr_ofs = l_r.ptr;
                  l_nxt.wr_dat = sr_full;
                  l_nxt.ptr = 7'(l_r.ptr + 7'h1);
                  l_nxt.wrote = 1'b1;
                  l_nxt.st = SMB_ACK_W;
                end
              end
            endcase
          end
        end
        SMB_ACK_A: begin
          l_nxt.bcnt = 3'h0;
          if (l_r.rw) begin
            l_nxt.st = SMB_TX;
            if (l_r.blk) begin
              l_nxt.txsr = BLK_COUNT;
            end else begin
              l_nxt.txsr = s_r.rd_data;
              l_nxt.ptr = 7'(l_r.ptr + 7'h1);
              l_nxt.rd_ofs = 7'(l_r.ptr + 7'h1);
              l_nxt.rd_tgl = ~l_r.rd_tgl;
            end
          end else begin
            l_nxt.st = SMB_CMD;
            l_nxt.cmd_ok = 1'b0;
            l_nxt.wrote = 1'b0;
          end
        end
        SMB_ACK_C: begin
          l_nxt.bcnt = 3'h0;
          l_nxt.st = (l_r.blk && !l_r.byp[1]) ? SMB_CNT : SMB_WDAT;
        end
        SMB_ACK_N, SMB_ACK_W: begin
          l_nxt.bcnt = 3'h0;
          l_nxt.st = SMB_WDAT;
        end
        SMB_TX: begin
          l_nxt.txsr = {l_r.txsr[6:0], 1'b0};
          l_nxt.bcnt = 3'(l_r.bcnt + 3'h1);
          if (l_r.bcnt == 3'(SMB_BIT_LAST)) begin
            l_nxt.st = SMB_RACK;
          end
        end
        SMB_RACK: begin
          // Host acknowledge asks for the next ascending byte; a refusal
          // ends the read and the line is released
          l_nxt.bcnt = 3'h0;
          if (!sda_i) begin
            l_nxt.st = SMB_TX;
            l_nxt.txsr = s_r.rd_data;
            l_nxt.ptr = 7'(l_r.ptr + 7'h1);
            l_nxt.rd_ofs = 7'(l_r.ptr + 7'h1);
            l_nxt.rd_tgl = ~l_r.rd_tgl;
          end else begin
            l_nxt.st = SMB_IDLE;
          end
        end
        default: begin
          l_nxt.st = SMB_IDLE;
        end
      endcase
    end
  end

  // Link state register; the serial clock stops between frames
  always_ff @(posedge scl_i or negedge rstn_i) begin
    if (!rstn_i) begin
      l_r <= LINK_RST;
    end else begin
      l_r <= l_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Data line driver, on the falling serial clock
  // ----------------------------------------------------------------------
  // Changing the line only while the clock is low keeps starts and stops
  // from being faked by our own drive
  always_comb begin
    case (l_r.st)
      SMB_ACK_A, SMB_ACK_C, SMB_ACK_N, SMB_ACK_W: sda_oe_nxt = 1'b1;
      SMB_TX: sda_oe_nxt = ~l_r.txsr[7];
      default: sda_oe_nxt = 1'b0;
    endcase
  end

  always_ff @(negedge scl_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sda_oe_r <= 1'b0;
    end else begin
      sda_oe_r <= sda_oe_nxt;
    end
  end

  assign sda_o = 1'b0;  // Open drain: only ever pulls low
  assign sda_oe_o = sda_oe_r;

  // ----------------------------------------------------------------------
  // Write buffer between the link and the register file
  // ----------------------------------------------------------------------
  // A pending write is held in the toggle handshake until the buffer takes
  // it; a further write while one waits cancels the toggle and drops both
  assign wr_pend = (s_r.wsync[1] != s_r.wseen);
  assign commit = fifo_out_valid & upd_ready_i;

  smb_fifo2 #(
    .W(FW),
    .DEPTH(FIFO_DEPTH)
  ) u_wbuf (
    .clk_i(clk_sys_i),
    .rstn_i(rstn_i),
    .en_i(ce_i),
    .in_valid_i(wr_pend),
    .in_data_i({l_r.wr_ofs, l_r.wr_dat}),
    .in_ready_o(fifo_in_ready),
    .out_valid_o(fifo_out_valid),
    .out_data_o(fifo_out_data),
    .out_ready_i(upd_ready_i)
  );

  // ----------------------------------------------------------------------
  // Register file, on the system clock
  // ----------------------------------------------------------------------
  // Offset and data words change with each toggle and then hold for many
  // link clocks, so only the toggles pass through two flip-flops
  always_comb begin
    s_nxt = s_r;
    s_nxt.wsync = {s_r.wsync[0], l_r.wr_tgl};
    s_nxt.rsync = {s_r.rsync[0], l_r.rd_tgl};
    if (wr_pend && fifo_in_ready) begin
      s_nxt.wseen = s_r.wsync[1];
    end
    if (commit && in_range(fifo_out_data[FW-1:8])) begin
      s_nxt.regs[int'(fifo_out_data[FW-1:8])*8 +: 8] = fifo_out_data[7:0];
    end
    if (s_r.rsync[1] != s_r.rseen) begin
      s_nxt.rseen = s_r.rsync[1];
      s_nxt.rd_data = byte_rd(s_r.regs, l_r.rd_ofs);
    end
  end

  // Defaults load at reset so the part runs without any access
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_r <= SYS_RST;
    end else if (ce_i) begin
      s_r <= s_nxt;
    end
  end

  assign cfg_o = s_r.regs;

endmodule

`default_nettype wire

// [verif/smb_host.sv]
/*
  Behavioural model of the system host that clocks the serial link.
  Assumes an external pull-up on the data line; the link clock stands
  high between frames and is low only inside a frame.
*/
`timescale 1ns/1ps
`default_nettype none
module smb_host (
  output var logic scl_o,
  output var logic sda_pull_o,
  input wire logic sda_i
);
  localparam int Q = 16;
  // ----------------------------------------------------------------
  // Link conditions and bytes
  // ----------------------------------------------------------------
  // Idle bus: clock high, data released
  initial begin
    scl_o = 1'b1;
    sda_pull_o = 1'b0;
  end
  // Start or repeated start; long phases so a 20 ns sampler sees them
  task automatic start_cond();
    sda_pull_o = 1'b0;
    #Q scl_o = 1'b1;
    #(2*Q) sda_pull_o = 1'b1;
    #(2*Q) scl_o = 1'b0;
    #Q;
  endtask
  // Data rises while the clock is high
  task automatic stop_cond();
    sda_pull_o = 1'b1;
    #Q scl_o = 1'b1;
    #(2*Q) sda_pull_o = 1'b0;
    #(2*Q);
  endtask
  // Most significant bit first; gap lets the slave's system side keep up
  task automatic put_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_pull_o = !b[i];
      #Q scl_o = 1'b1;
      #(2*Q) scl_o = 1'b0;
      #Q;
    end
    sda_pull_o = 1'b0;
    #Q scl_o = 1'b1;
    #Q ack = !sda_i;
    #Q scl_o = 1'b0;
    #(Q+9*64);
  endtask
  // Host acknowledges or refuses each byte the slave returns
  task automatic get_byte(input logic ack_it, output logic [7:0] b);
    sda_pull_o = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      #Q scl_o = 1'b1;
      #Q b[i] = sda_i;
      #Q scl_o = 1'b0;
      #Q;
    end
    sda_pull_o = ack_it;
    #Q scl_o = 1'b1;
    #(2*Q) scl_o = 1'b0;
    #Q sda_pull_o = 1'b0;
    #(9*64);
  endtask
endmodule
`default_nettype wire

// [verif/smb_slave_props.sv]
/*
  Checker for the serial slave: acknowledge, drive timing, register update.
  Assumes the system clock samples the link far faster than its bit rate.
*/
`timescale 1ns/1ps
`default_nettype none
module smb_slave_props
  import smb_pkg::*;
#(
  parameter int NUM_BYTES = 8
) (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic upd_ready_i,
  input wire logic [NUM_BYTES*SMB_BYTE_W-1:0] cfg_o
);
  // ----------------------------------------------------------------
  // Link position tracking
  // ----------------------------------------------------------------
  logic scl_q, sda_q, wr_q, rise;
  logic [3:0] bit_q;
  logic [1:0] byt_q;
  logic [7:0] sh_q;
  // Rising link clock as seen by the system clock
  assign rise = !scl_q && scl_i;
  // Bit and byte count since the last start, own write address flag kept
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      wr_q <= 1'b0;
      bit_q <= 4'h0;
      byt_q <= 2'h0;
      sh_q <= 8'h00;
    end else begin
      scl_q <= scl_i;
      sda_q <= sda_i;
      if (scl_q && scl_i && sda_q && !sda_i) begin
        bit_q <= 4'h0;
        byt_q <= 2'h0;
      end else if (rise && bit_q == 4'h8) begin
        bit_q <= 4'h0;
        // Saturate so data bytes deep in a block never pass for an address byte
        byt_q <= (byt_q == 2'h3) ? 2'h3 : 2'(byt_q + 2'h1);
        if (byt_q == 2'h0) wr_q <= (sh_q == {SMB_SLV_ADDR, 1'b0});
      end else if (rise) begin
        bit_q <= bit_q + 4'h1;
        sh_q <= {sh_q[6:0], sda_i};
      end
    end
  end
  // Number of register bytes that differ; a write must touch one only
  function automatic int diff_bytes(input logic [NUM_BYTES*8-1:0] a,
    input logic [NUM_BYTES*8-1:0] b);
    int n;
    n = 0;
    for (int i = 0; i < NUM_BYTES; i++) if (a[8*i+:8] != b[8*i+:8]) n++;
    return n;
  endfunction
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  a_addr_ack: assert property (rise && bit_q == 4'h8 && byt_q == 2'h0 &&
      sh_q == {SMB_SLV_ADDR, 1'b0} |-> sda_oe_o) else $error("own address not acknowledged");
  a_addr_ignore: assert property (rise && bit_q == 4'h8 && byt_q == 2'h0 &&
      sh_q[7:1] != SMB_SLV_ADDR |-> !sda_oe_o) else $error("foreign address acknowledged");
  a_addr_quiet: assert property (rise && byt_q == 2'h0 && bit_q != 4'h8 |-> !sda_oe_o)
    else $error("data line driven during address bits");
  a_cmd_ack: assert property (rise && bit_q == 4'h8 && byt_q == 2'h1 && wr_q |-> sda_oe_o)
    else $error("command byte not acknowledged");
  a_oe_edge: assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("data drive changed while link clock high");
  a_sda_low: assert property (sda_o == 1'b0) else $error("open drain output not low");
  a_cfg_commit: assert property ($changed(cfg_o) |-> $past(upd_ready_i) && $past(ce_i))
    else $error("register changed without commit");
  a_cfg_freeze: assert property (!ce_i |=> $stable(cfg_o))
    else $error("register moved while frozen");
  a_cfg_one_byte: assert property ($changed(cfg_o) |-> diff_bytes(cfg_o, $past(cfg_o)) == 1)
    else $error("more than one byte changed at once");
endmodule
bind smb_slave smb_slave_props #(.NUM_BYTES(NUM_BYTES)) i_smb_slave_props (
  .clk_sys_i(clk_sys_i),
  .rstn_i(rstn_i),
  .ce_i(ce_i),
  .scl_i(scl_i),
  .sda_i(sda_i),
  .sda_o(sda_o),
  .sda_oe_o(sda_oe_o),
  .upd_ready_i(upd_ready_i),
  .cfg_o(cfg_o)
);
`default_nettype wire

// [verif/test_smbus_slave_register_access.sv]
/*
  Self-checking bench for the serial slave with a host model on the link.
  Assumes the wire has a pull-up and the host paces bytes with idle gaps.
*/
`timescale 1ns/1ps
`default_nettype none
module test_smbus_slave_register_access;
  import smb_pkg::*;
  localparam int CW = SMB_NUM_BYTES * SMB_BYTE_W;
  logic clk_sys_i = 1'b0, rstn_i = 1'b0, ce_i = 1'b1, bypass = 1'b0, upd_rdy = 1'b1;
  logic scl_w, pull_w, oe_w, sda_o_w, sda_w;
  logic [CW-1:0] cfg_w, exp_cfg = SMB_RST_TBL;
  int miscompares = 0, comparisons = 0;
  // Pulled-up wire, low while either party pulls it
  assign sda_w = !(pull_w || oe_w);
  // System clock, 20 ns period
  always #10 clk_sys_i = ~clk_sys_i;
  smb_slave i_smb_slave (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .ce_i(ce_i), .scl_i(scl_w),
    .sda_i(sda_w), .sda_o(sda_o_w), .sda_oe_o(oe_w), .byte_cnt_bypass_i(bypass),
    .upd_ready_i(upd_rdy), .cfg_o(cfg_w));
  smb_host i_smb_host (.scl_o(scl_w), .sda_pull_o(pull_w), .sda_i(sda_w));
  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [CW-1:0] got, input logic [CW-1:0] want);
    comparisons++;
    if (got !== want) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, want);
    end
  endtask
  // Bounded wait for the committed image, then compare
  task automatic settle();
    // Look just after the edge, once the image has settled
    for (int n = 0; n < 40 && cfg_w !== exp_cfg; n++) begin
      @(posedge clk_sys_i);
      #1;
    end
    chk(cfg_w, exp_cfg);
  endtask
  task automatic send(input logic [7:0] b, input logic want);
    logic ack;
    i_smb_host.put_byte(b, ack);
    chk(CW'(ack), CW'(want));
  endtask
  task automatic recv(input logic ack_it, input logic [7:0] want);
    logic [7:0] b;
    i_smb_host.get_byte(ack_it, b);
    chk(CW'(b), CW'(want));
  endtask
  // Odd-ns phase keeps link edges off the system clock edges
  task automatic open_frame(input logic [7:0] a, input logic want);
    @(posedge clk_sys_i);
    #1 i_smb_host.start_cond();
    send(a, want);
  endtask
  task automatic byte_write(input logic [6:0] ofs, input logic [7:0] v);
    open_frame(8'hd2, 1'b1);
    send({1'b1, ofs}, 1'b1);
    send(v, 1'b1);
    i_smb_host.stop_cond();
    exp_cfg[8*ofs+:8] = v;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_writes();
    chk(cfg_w, SMB_RST_TBL);
    @(posedge clk_sys_i);
    #1 ce_i = 1'b0;
    byte_write(7'h01, 8'h5a);
    repeat (20) @(posedge clk_sys_i);
    chk(cfg_w, SMB_RST_TBL);
    #1 ce_i = 1'b1;
    settle();
    byte_write(7'h07, 8'hc3);
    settle();
  endtask
  task automatic t_reads();
    logic [6:0] ofs [3] = '{7'h01, 7'h00, 7'h07};
    foreach (ofs[k]) begin
      open_frame(8'hd2, 1'b1);
      send({1'b1, ofs[k]}, 1'b1);
      i_smb_host.start_cond();
      send(8'hd3, 1'b1);
      recv(1'b0, exp_cfg[8*ofs[k]+:8]);
      i_smb_host.stop_cond();
    end
  endtask
  task automatic t_foreign();
    // Byte mode takes one data byte; a second one must go unanswered
    open_frame(8'hd2, 1'b1);
    send(8'h82, 1'b1);
    send(8'h3c, 1'b1);
    send(8'h4b, 1'b0);
    i_smb_host.stop_cond();
    exp_cfg[23:16] = 8'h3c;
    open_frame(8'hd4, 1'b0);
    send(8'h81, 1'b0);
    send(8'h00, 1'b0);
    i_smb_host.stop_cond();
    repeat (20) @(posedge clk_sys_i);
    chk(cfg_w, exp_cfg);
  endtask
  task automatic t_block_write();
    open_frame(8'hd2, 1'b1);
    send(8'h00, 1'b1);
    send(8'h03, 1'b1);
    for (int i = 0; i < 3; i++) begin
      send(8'ha1 + 8'(i), 1'b1);
      exp_cfg[8*i+:8] = 8'ha1 + 8'(i);
    end
    i_smb_host.stop_cond();
    settle();
    @(posedge clk_sys_i);
    #1 bypass = 1'b1;
    upd_rdy = 1'b0;
    open_frame(8'hd2, 1'b1);
    send(8'h00, 1'b1);
    send(8'hb1, 1'b1);
    send(8'hb2, 1'b1);
    i_smb_host.stop_cond();
    repeat (20) @(posedge clk_sys_i);
    chk(cfg_w, exp_cfg);
    exp_cfg[15:0] = 16'hb2b1;
    #1 upd_rdy = 1'b1;
    settle();
  endtask
  task automatic t_block_read();
    open_frame(8'hd2, 1'b1);
    send(8'h00, 1'b1);
    i_smb_host.start_cond();
    send(8'hd3, 1'b1);
    recv(1'b1, 8'(SMB_NUM_BYTES));
    for (int i = 0; i < 4; i++) recv(i != 3, exp_cfg[8*i+:8]);
    i_smb_host.stop_cond();
  endtask
  // ----------------------------------------------------------------
  // Sequence, verdict and watchdog
  // ----------------------------------------------------------------
  task automatic conclude();
    if (miscompares == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Reset for four cycles, then every scenario in turn
  initial begin
    repeat (4) @(posedge clk_sys_i);
    #1 rstn_i = 1'b1;
    t_writes();
    t_reads();
    t_foreign();
    t_block_write();
    t_block_read();
    conclude();
  end
  // Roughly eight times the expected run length
  initial begin
    #400000;
    miscompares++;
    conclude();
  end
endmodule
`default_nettype wire
